// File: rtl/fixed_run_pkg.sv
package fixed_run_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register bus geometry and byte offsets
  localparam int ADDR_W = 6; // Byte address width
  localparam int DATA_W = 32; // Bus data width
  localparam logic [5:0] OFS_CTRL = 6'h00; // Control bits
  localparam logic [5:0] OFS_DISP = 6'h04; // Displacement, reference units
  localparam logic [5:0] OFS_SPEED = 6'h08; // Run speed, rpm
  localparam logic [5:0] OFS_RAMP = 6'h0c; // Ramp time, ms
  localparam logic [5:0] OFS_STATUS = 6'h10; // Sequencer state, read only
  localparam logic [5:0] OFS_COUNT = 6'h14; // Input reference counter
  localparam logic [5:0] OFS_IRQ_STAT = 6'h18; // Sticky events, read only
  localparam logic [5:0] OFS_IRQ_CLR = 6'h1c; // Write one to clear
  localparam logic [5:0] OFS_IRQ_EN = 6'h20; // Interrupt enables

  ////////////////////////////////////////////////////////////////////////
  // Field positions of the control register
  localparam int CTRL_EN = 0; // Function enable
  localparam int CTRL_UNLOCK = 1; // Post-run unlock select
  localparam int CTRL_POL = 2; // Trigger polarity, 1 = rising edge
  localparam int CTRL_FN = 3; // Trigger input assigned to this function
  localparam int CTRL_INH = 4; // Inhibit function assigned to an input

  // Interrupt event bits
  localparam int IRQ_W = 3;
  localparam int IRQ_START = 0; // Run accepted
  localparam int IRQ_DONE = 1; // Run completed
  localparam int IRQ_REFUSE = 2; // Edge seen but not honoured

  ////////////////////////////////////////////////////////////////////////
  // Value ranges and reset values
  localparam logic [30:0] DISP_RST = 31'h0000_2710; // 10000 units
  localparam logic [30:0] DISP_MAX = 31'h4000_0000; // 1073741824 units
  localparam logic [12:0] SPEED_RST = 13'h00c8; // 200 rpm
  localparam logic [12:0] SPEED_MAX = 13'h1770; // 6000 rpm
  localparam logic [9:0] RAMP_RST = 10'h00a; // 10 ms
  localparam logic [9:0] RAMP_MAX = 10'h3e8; // 1000 ms
  localparam logic [16:0] MIN_SPEED_RPM = 17'h0000a; // 10 rpm
  localparam logic [4:0] CTRL_RST = 5'h0e; // Disabled, unlock, rising, assigned

  ////////////////////////////////////////////////////////////////////////
  // Timing: one profile sample per millisecond
  localparam int CLK_PERIOD_NS = 8;
  localparam int SAMPLE_TIME_NS = 1000000;
  localparam int SAMPLE_CYCLES_DOC = SAMPLE_TIME_NS / CLK_PERIOD_NS;
  localparam logic [3:0] DIV_STEPS = 4'hd; // Quotient bits of speed / ramp

  ////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic inh_used; // Inhibit function assigned
    logic trig_fn; // Trigger input serves this function
    logic pol; // Active edge, 1 = rising
    logic unlock; // Stay locked after run until cleared
    logic en; // Function enabled
  } cfg_t;

  typedef struct packed {
    logic valid; // Increment present this cycle
    logic signed [31:0] delta; // Increment, reference units
  } ref_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PREP = 2'b01,
    ST_RUN = 2'b11,
    ST_LOCK = 2'b10
  } state_t;

endpackage

// File: rtl/fixed_run_seq.sv
`timescale 1ns/1ps
// What this block does
// - Ignore trigger while homing runs
// - Trigger abandons motion, runs preset distance, same direction
// - Reject other references and retrigger during run
// - Counter accumulates only the run's reference during run
// - After run, lock or unlock per setting
// - Discard references arriving during run
// - Completion raises run-done and positioning-done
// - Run-done ignores servo-on and trigger polarity
// - Honour trigger if speed >=10 or settings nonzero
// - Active assigned inhibit input refuses triggers
// - Bypass averaging filter throughout the run
// - Lock-clear input drops the post-run lock
// - Trigger input serves only this function
// - Trigger on selected edge, not level
// - Run speed from setting, else pre-trigger speed
// - Run-done stays low while displacement incomplete
module fixed_run_seq
  import fixed_run_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYCLES_DOC // Clock cycles per profile sample
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic trigger_digital_input,
  input wire logic fixed_run_inhibit,
  input wire logic fixed_run_lock_clear,
  input wire logic servo_on,
  input wire logic position_mode,
  input wire logic homing_active,
  input wire logic in_window,
  input wire logic signed [15:0] motor_speed_rpm,
  input wire ref_t ext_ref,
  output ref_t pos_ref,
  output logic filter_bypass,
  output logic fixed_run_done,
  output logic positioning_done,
  output logic ref_locked,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration check: the sample counter needs at least one cycle
  if (SAMPLE_CYCLES < 1) begin : g_chk
    $error("SAMPLE_CYCLES must be at least 1");
  end

  localparam int TW = (SAMPLE_CYCLES > 1) ? $clog2(SAMPLE_CYCLES) : 1;
  localparam logic [TW-1:0] TICK_LAST = TW'(SAMPLE_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  state_t state_r; // Sequencer state
  state_t state_nxt; // Its next value
  cfg_t cfg_r; // Control bits
  logic [30:0] disp_r; // Configured displacement
  logic [12:0] speed_r; // Configured run speed
  logic [9:0] ramp_r; // Configured ramp time
  logic [IRQ_W-1:0] irq_stat_r; // Sticky events
  logic [IRQ_W-1:0] irq_stat_nxt; // Their next value
  logic [IRQ_W-1:0] irq_en_r; // Interrupt enables
  logic [31:0] ref_count_r; // Input reference counter
  logic [TW-1:0] tick_cnt_r; // Sample divider
  logic tick; // One cycle per sample
  logic trig_d_r; // Trigger input, one cycle old
  logic last_neg_r; // Direction of the last external increment
  logic [30:0] rem_r; // Displacement still to issue
  logic [30:0] acc_dist_r; // Distance issued before braking
  logic [12:0] vel_r; // Present increment per sample
  logic [12:0] vmax_r; // Latched run speed
  logic [9:0] ramp_lat_r; // Latched ramp time
  logic decel_r; // Ramp-down under way
  logic dir_neg_r; // Run goes negative
  logic [10:0] div_rem_r; // Divider remainder
  logic [12:0] div_quo_r; // Divider quotient, becomes the ramp step
  logic [3:0] div_cnt_r; // Divider steps left
  ref_t ref_nxt; // Reference passed on next cycle
  logic [16:0] spd_abs; // Magnitude of pre-trigger speed
  logic speed_ok; // Pre-trigger speed fast enough
  logic edge_seen; // Active edge on the trigger input
  logic allowed; // All trigger conditions met
  logic start; // Run accepted this cycle
  logic refuse; // Edge seen but refused
  logic complete; // Run finishes this cycle
  logic abort; // Run dropped by mode or servo loss
  logic [12:0] run_speed; // Run speed chosen at trigger
  logic [12:0] step; // Ramp step per sample
  logic [13:0] vel_up; // Accelerated speed, one bit of headroom
  logic [12:0] vel_now; // Speed for this sample
  logic [30:0] inc; // Increment issued this sample
  logic [10:0] div_trial; // Divider shifted remainder
  logic running; // Prep or run

  ////////////////////////////////////////////////////////////////////////
  // Sample tick divider, free running
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt_r <= '0;
    end else if (clk_en) begin
      tick_cnt_r <= (tick_cnt_r == TICK_LAST) ? '0 : tick_cnt_r + 1'b1;
    end
  end

  assign tick = (tick_cnt_r == TICK_LAST);

  ////////////////////////////////////////////////////////////////////////
  // Trigger conditions
  always_comb begin
    spd_abs = motor_speed_rpm[15] ? 17'(-$signed({motor_speed_rpm[15], motor_speed_rpm}))
                                  : {1'b0, motor_speed_rpm};
    speed_ok = (spd_abs >= MIN_SPEED_RPM);
    // Edge, never level; the polarity picks which edge
    edge_seen = cfg_r.pol ? (trigger_digital_input & ~trig_d_r)
                          : (~trigger_digital_input & trig_d_r);
    allowed = position_mode & servo_on & cfg_r.en;
    allowed = allowed & ~homing_active;
    allowed = allowed & ~(cfg_r.inh_used & fixed_run_inhibit);
    allowed = allowed & (speed_ok | ((speed_r != '0) & (disp_r != '0)));
    allowed = allowed & (state_r == ST_IDLE);
    // Only the dedicated input, and only when assigned to this function
    start = edge_seen & cfg_r.trig_fn & allowed;
    refuse = edge_seen & cfg_r.trig_fn & ~allowed;
    // Setting wins when nonzero, else the motor's own speed
    if (speed_r != '0) begin
      run_speed = speed_r;
    end else if (spd_abs > {4'h0, SPEED_MAX}) begin
      run_speed = SPEED_MAX;
    end else begin
      run_speed = spd_abs[12:0];
    end
  end

  // Previous trigger level for edge detection
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      trig_d_r <= 1'b0;
    end else if (clk_en) begin
      trig_d_r <= trigger_digital_input;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Profile arithmetic for one sample
  always_comb begin
    // A zero ramp time means a jump straight to run speed
    if (ramp_lat_r == '0) begin
      step = vmax_r;
    end else if (div_quo_r == '0) begin
      step = 13'h0001;
    end else begin
      step = div_quo_r;
    end
    vel_up = {1'b0, vel_r} + {1'b0, step};
    // Ramp down mirrors the ramp up, never below one step
    if (decel_r) begin
      vel_now = (vel_r > step) ? vel_r - step : step;
    end else begin
      vel_now = (vel_up > {1'b0, vmax_r}) ? vmax_r : vel_up[12:0];
    end
    // Clip the last sample so the run ends on the exact distance
    inc = ({18'h0, vel_now} > rem_r) ? rem_r : {18'h0, vel_now};
    div_trial = {div_rem_r[9:0], div_quo_r[12]};
    running = (state_r == ST_PREP) || (state_r == ST_RUN);
    abort = running & ~(servo_on & position_mode);
    complete = (state_r == ST_RUN) & ~abort & ((rem_r == '0) | (tick & (inc == rem_r)));
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start) begin
          state_nxt = ST_PREP;
        end
      end
      ST_PREP: begin
        if (abort) begin
          state_nxt = ST_IDLE;
        end else if (div_cnt_r == 4'h1) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (abort) begin
          state_nxt = ST_IDLE;
        end else if (complete) begin
          // Hold the lock only when unlock is selected
          state_nxt = cfg_r.unlock ? ST_LOCK : ST_IDLE;
        end
      end
      ST_LOCK: begin
        if (fixed_run_lock_clear) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ramp step: restoring divide of run speed by ramp samples
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_rem_r <= '0;
      div_quo_r <= '0;
      div_cnt_r <= '0;
    end else if (clk_en) begin
      if (start) begin
        div_rem_r <= '0;
        div_quo_r <= run_speed;
        div_cnt_r <= DIV_STEPS;
      end else if (state_r == ST_PREP) begin
        // One quotient bit per cycle; the quotient then stays for the run
        if (div_trial >= {1'b0, ramp_lat_r}) begin
          div_rem_r <= div_trial - {1'b0, ramp_lat_r};
          div_quo_r <= {div_quo_r[11:0], 1'b1};
        end else begin
          div_rem_r <= div_trial;
          div_quo_r <= {div_quo_r[11:0], 1'b0};
        end
        div_cnt_r <= div_cnt_r - 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Run state: latched settings, speed and distance left
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rem_r <= '0;
      acc_dist_r <= '0;
      vel_r <= '0;
      vmax_r <= '0;
      ramp_lat_r <= '0;
      decel_r <= 1'b0;
      dir_neg_r <= 1'b0;
    end else if (clk_en) begin
      if (start) begin
        // Settings change in real time, so a run keeps its own copy
        rem_r <= disp_r;
        acc_dist_r <= '0;
        vel_r <= '0;
        vmax_r <= run_speed;
        ramp_lat_r <= ramp_r;
        decel_r <= 1'b0;
        // Keep the direction of the motion that was interrupted
        dir_neg_r <= speed_ok ? motor_speed_rpm[15] : last_neg_r;
      end else if ((state_r == ST_RUN) && tick && (rem_r != '0)) begin
        rem_r <= rem_r - inc;
        vel_r <= vel_now;
        if (!decel_r) begin
          acc_dist_r <= acc_dist_r + inc;
          // Start braking once what is left is no more than what has been issued so far
          decel_r <= ((rem_r - inc) <= (acc_dist_r + inc));
        end
      end
    end
  end

  // Direction memory for triggers from near standstill
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      last_neg_r <= 1'b0;
    end else if (clk_en) begin
      if ((state_r == ST_IDLE) && ext_ref.valid && (ext_ref.delta != '0)) begin
        last_neg_r <= ext_ref.delta[31];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reference path to the position loop
  always_comb begin
    // Outside idle, external increments are dropped, never queued
    ref_nxt = '0;
    if (state_r == ST_IDLE) begin
      ref_nxt = ext_ref;
    end else if ((state_r == ST_RUN) && tick && (rem_r != '0) && !abort) begin
      ref_nxt.valid = 1'b1;
      ref_nxt.delta = dir_neg_r ? -$signed({1'b0, inc}) : $signed({1'b0, inc});
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pos_ref <= '0;
      ref_count_r <= '0;
    end else if (clk_en) begin
      pos_ref <= ref_nxt;
      // Counts only what is passed on, so a run counts itself alone
      if (ref_nxt.valid) begin
        ref_count_r <= ref_count_r + ref_nxt.delta;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Discrete outputs
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fixed_run_done <= 1'b0;
      positioning_done <= 1'b0;
      filter_bypass <= 1'b0;
      ref_locked <= 1'b0;
    end else if (clk_en) begin
      // Low from acceptance until the last increment is out
      if (start) begin
        fixed_run_done <= 1'b0;
      end else if (complete) begin
        fixed_run_done <= 1'b1;
      end
      // Positioning-done follows the window, forced at run end
      if (complete) begin
        positioning_done <= 1'b1;
      end else begin
        positioning_done <= ~running & ~start & servo_on & in_window;
      end
      filter_bypass <= (state_nxt == ST_PREP) || (state_nxt == ST_RUN);
      ref_locked <= (state_nxt != ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfg_r <= cfg_t'(CTRL_RST);
      disp_r <= DISP_RST;
      speed_r <= SPEED_RST;
      ramp_r <= RAMP_RST;
      irq_en_r <= '0;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        OFS_CTRL: begin
          cfg_r <= cfg_t'(reg_wdata[4:0]);
        end
        // Out-of-range values saturate at the top of their range
        OFS_DISP: begin
          disp_r <= (reg_wdata[30:0] > DISP_MAX || reg_wdata[31]) ? DISP_MAX
                                                                  : reg_wdata[30:0];
        end
        OFS_SPEED: begin
          speed_r <= (reg_wdata > {19'h0, SPEED_MAX}) ? SPEED_MAX : reg_wdata[12:0];
        end
        OFS_RAMP: begin
          ramp_r <= (reg_wdata > {22'h0, RAMP_MAX}) ? RAMP_MAX : reg_wdata[9:0];
        end
        OFS_IRQ_EN: begin
          irq_en_r <= reg_wdata[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status: a new event beats a clear in the same cycle
  always_comb begin
    irq_stat_nxt = irq_stat_r;
    if (reg_wr && (reg_addr == OFS_IRQ_CLR)) begin
      irq_stat_nxt = irq_stat_nxt & ~reg_wdata[IRQ_W-1:0];
    end
    irq_stat_nxt[IRQ_START] = irq_stat_nxt[IRQ_START] | start;
    irq_stat_nxt[IRQ_DONE] = irq_stat_nxt[IRQ_DONE] | complete;
    irq_stat_nxt[IRQ_REFUSE] = irq_stat_nxt[IRQ_REFUSE] | refuse;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_r <= '0;
      irq <= 1'b0;
    end else if (clk_en) begin
      irq_stat_r <= irq_stat_nxt;
      irq <= |(irq_stat_nxt & irq_en_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port: data in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= '0;
      if (reg_rd) begin
        case (reg_addr)
          OFS_CTRL: reg_rdata <= {27'h0, cfg_r};
          OFS_DISP: reg_rdata <= {1'b0, disp_r};
          OFS_SPEED: reg_rdata <= {19'h0, speed_r};
          OFS_RAMP: reg_rdata <= {22'h0, ramp_r};
          OFS_STATUS: reg_rdata <= {28'h0, fixed_run_done, ref_locked, state_r};
          OFS_COUNT: reg_rdata <= ref_count_r;
          OFS_IRQ_STAT: reg_rdata <= {29'h0, irq_stat_r};
          OFS_IRQ_EN: reg_rdata <= {29'h0, irq_en_r};
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

endmodule

// File: verification/fixed_run_chk.sv
`timescale 1ns/1ps
// Watches run entry, completion and post-run lock at the sequencer ports
module fixed_run_chk
  import fixed_run_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic trigger_digital_input,
  input wire logic fixed_run_lock_clear,
  input wire logic servo_on,
  input wire logic position_mode,
  input wire logic homing_active,
  input wire ref_t pos_ref,
  input wire logic filter_bypass,
  input wire logic fixed_run_done,
  input wire logic positioning_done,
  input wire logic ref_locked
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  // Idle to bypassed: the run has begun
  sequence s_start;
    !filter_bypass ##1 filter_bypass;
  endsequence
  // Two settled cycles of the post-run lock
  sequence s_held;
    (ref_locked && !filter_bypass) ##1 (ref_locked && !filter_bypass);
  endsequence
  property p_start; s_start |-> ref_locked && !fixed_run_done; endproperty
  property p_edge;
    $rose(filter_bypass) |-> $past(trigger_digital_input) != $past(trigger_digital_input, 2);
  endproperty
  property p_cond; $rose(filter_bypass) |-> $past(servo_on) && $past(position_mode); endproperty
  property p_homing; $rose(filter_bypass) |-> !$past(homing_active); endproperty
  property p_bypass; filter_bypass |-> ref_locked; endproperty
  property p_quiet; s_held |-> !pos_ref.valid; endproperty
  property p_positioning_done; $rose(fixed_run_done) |-> positioning_done && !filter_bypass; endproperty
  property p_open; $fell(fixed_run_done) |-> filter_bypass && ref_locked; endproperty
  // Idle follows the clear, the registered lock flag a cycle later at most
  property p_clear;
    (ref_locked && !filter_bypass && fixed_run_lock_clear) |-> ##[1:2] !ref_locked;
  endproperty
  a_start: assert property (p_start) else $error("run began unlocked");
  a_edge: assert property (p_edge) else $error("run began without edge");
  a_cond: assert property (p_cond) else $error("run began out of mode");
  a_homing: assert property (p_homing) else $error("run began in homing");
  a_bypass: assert property (p_bypass) else $error("bypass while unlocked");
  a_quiet: assert property (p_quiet) else $error("reference while locked");
  a_positioning_done: assert property (p_positioning_done) else $error("done without positioning_done");
  a_open: assert property (p_open) else $error("done dropped outside run");
  a_clear: assert property (p_clear) else $error("lock not cleared");
endmodule
bind fixed_run_seq fixed_run_chk fixed_run_chk_inst (.clk_sys(clk_sys), .reset_n(reset_n),
  .trigger_digital_input(trigger_digital_input), .fixed_run_lock_clear(fixed_run_lock_clear),
  .servo_on(servo_on), .position_mode(position_mode), .homing_active(homing_active),
  .pos_ref(pos_ref), .filter_bypass(filter_bypass), .fixed_run_done(fixed_run_done),
  .positioning_done(positioning_done), .ref_locked(ref_locked));

// File: verification/host_model.sv
`timescale 1ns/1ps
// Host side: drives the trigger pin and counts completions it sees
module host_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic go,
  input wire logic hold,
  input wire logic pol,
  input wire logic fixed_run_done,
  output logic trigger_digital_input,
  output logic [7:0] acks
);
  logic done_r; // Last sample of the done output
  // Active level on request; hold keeps it to show a level is not a trigger
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      trigger_digital_input <= 1'b0;
    end else if (go) begin
      trigger_digital_input <= pol;
    end else if (!hold) begin
      trigger_digital_input <= !pol;
    end
  end
  // A rising done is taken as the finish of the run
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      done_r <= 1'b0;
      acks <= 8'h00;
    end else begin
      done_r <= fixed_run_done;
      if (fixed_run_done && !done_r) begin
        acks <= acks + 8'h01;
      end
    end
  end
endmodule

// File: verification/tb_interrupt_fixed_distance_positioning.sv
`timescale 1ns/1ps
module tb_interrupt_fixed_distance_positioning
  import fixed_run_pkg::*;
;
  logic clk_sys = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic go = 1'b0, hold = 1'b0, pol = 1'b1; // Host model requests
  logic fixed_run_inhibit = 1'b0, fixed_run_lock_clear = 1'b0, homing_active = 1'b0;
  logic servo_on = 1'b1, position_mode = 1'b1;
  logic signed [15:0] motor_speed_rpm = 16'sh0064;
  logic [ADDR_W-1:0] reg_addr = 6'h00;
  logic [DATA_W-1:0] reg_wdata = 32'h0, reg_rdata;
  ref_t ext_ref = '0, pos_ref;
  logic filter_bypass, fixed_run_done, positioning_done, ref_locked, irq, trig;
  logic [7:0] acks;
  logic signed [31:0] sum = 32'sh0; // Running total of emitted increments
  int n_errors = 0, num_checks = 0, cyc = 0;
  ////////////////////////////////////////
  // Short sample period keeps the runs brief
  fixed_run_seq #(.SAMPLE_CYCLES(4)) fixed_run_seq_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .clk_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trigger_digital_input(trig),
    .fixed_run_inhibit(fixed_run_inhibit), .fixed_run_lock_clear(fixed_run_lock_clear),
    .servo_on(servo_on), .position_mode(position_mode), .homing_active(homing_active),
    .in_window(1'b1), .motor_speed_rpm(motor_speed_rpm), .ext_ref(ext_ref),
    .pos_ref(pos_ref), .filter_bypass(filter_bypass), .fixed_run_done(fixed_run_done),
    .positioning_done(positioning_done), .ref_locked(ref_locked), .irq(irq));
  host_model host_model_inst (.clk_sys(clk_sys), .reset_n(reset_n), .go(go), .hold(hold),
    .pol(pol), .fixed_run_done(fixed_run_done), .trigger_digital_input(trig), .acks(acks));
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  // Accumulate increments; cut a hang short
  always @(posedge clk_sys) begin
    if (pos_ref.valid === 1'b1) sum <= sum + pos_ref.delta;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  ////////////////////////////////////////
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr_reg(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk_sys); reg_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task rd_chk(input string what, input logic [5:0] a, input logic [31:0] exp);
    @(posedge clk_sys); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk_sys); reg_rd <= 1'b0;
    #1 check(what, reg_rdata, exp);
  endtask
  task pulse_go;
    @(posedge clk_sys); go <= 1'b1;
    @(posedge clk_sys); go <= 1'b0;
  endtask
  task wait_done;
    int i;
    i = 0;
    while (fixed_run_done !== 1'b1 && i < 400) begin
      @(posedge clk_sys);
      i++;
    end
    #1 check("done", 32'(fixed_run_done), 32'h1);
    check("positioning_done", 32'(positioning_done), 32'h1);
  endtask
  ////////////////////////////////////////
  task t_reset;
    rd_chk("ctrl", OFS_CTRL, 32'h0e);
    rd_chk("disp", OFS_DISP, 32'h2710);
    rd_chk("speed", OFS_SPEED, 32'hc8);
    rd_chk("ramp", OFS_RAMP, 32'h0a);
    rd_chk("unmapped", 6'h3c, 32'h0);
    $display("reset test done");
  endtask
  task t_locked;
    wr_reg(OFS_CTRL, 32'h0f);
    wr_reg(OFS_DISP, 32'h14);
    wr_reg(OFS_SPEED, 32'h5);
    wr_reg(OFS_RAMP, 32'h0);
    wr_reg(OFS_IRQ_EN, 32'h7);
    pulse_go;
    repeat (3) @(posedge clk_sys);
    #1 check("bypass", 32'(filter_bypass), 32'h1);
    check("locked", 32'(ref_locked), 32'h1);
    @(posedge clk_sys); ext_ref <= '{1'b1, 32'sh3e8};
    @(posedge clk_sys); ext_ref <= '0;
    pulse_go; // Second trigger mid-run is refused
    wait_done;
    check("locked", 32'(ref_locked), 32'h1);
    rd_chk("status", OFS_STATUS, 32'h0e);
    check("sum", sum, 32'h14);
    rd_chk("irq stat", OFS_IRQ_STAT, 32'h7);
    check("irq", 32'(irq), 32'h1);
    wr_reg(OFS_IRQ_CLR, 32'h7);
    rd_chk("irq stat", OFS_IRQ_STAT, 32'h0);
    check("irq", 32'(irq), 32'h0);
    servo_on <= 1'b0; // Done must not follow servo-on
    repeat (3) @(posedge clk_sys);
    #1 check("done", 32'(fixed_run_done), 32'h1);
    servo_on <= 1'b1;
    pulse_go; // Still locked: refused
    repeat (20) @(posedge clk_sys);
    #1 check("bypass", 32'(filter_bypass), 32'h0);
    fixed_run_lock_clear <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 check("locked", 32'(ref_locked), 32'h0);
    fixed_run_lock_clear <= 1'b0;
    rd_chk("count", OFS_COUNT, 32'h14);
    wr_reg(OFS_IRQ_CLR, 32'h7);
    $display("locked run test done");
  endtask
  // Homing, inhibit, servo off and low speed in turn; the first with the interrupt masked
  task t_refuse;
    for (int k = 0; k < 4; k++) begin
      wr_reg(OFS_IRQ_EN, (k == 0) ? 32'h0 : 32'h4);
      case (k)
        0: homing_active <= 1'b1;
        1: begin fixed_run_inhibit <= 1'b1; wr_reg(OFS_CTRL, 32'h1f); end
        2: servo_on <= 1'b0;
        default: begin wr_reg(OFS_SPEED, 32'h0); motor_speed_rpm <= 16'sh0005; end
      endcase
      pulse_go;
      repeat (20) @(posedge clk_sys);
      #1 check("bypass", 32'(filter_bypass), 32'h0);
      check("irq", 32'(irq), 32'(k != 0));
      rd_chk("irq stat", OFS_IRQ_STAT, 32'h4);
      wr_reg(OFS_IRQ_CLR, 32'h7);
      homing_active <= 1'b0;
      fixed_run_inhibit <= 1'b0;
      servo_on <= 1'b1;
      motor_speed_rpm <= 16'sh0064;
      wr_reg(OFS_CTRL, 32'h0f);
      wr_reg(OFS_SPEED, 32'h5);
    end
    $display("refusal test done");
  endtask
  // Falling edge, reverse direction, speed from motor, no post-run lock
  task t_reverse;
    logic signed [31:0] base;
    wr_reg(OFS_CTRL, 32'h09);
    pol <= 1'b0;
    wr_reg(OFS_SPEED, 32'h0);
    wr_reg(OFS_RAMP, 32'h2);
    motor_speed_rpm <= 16'shff9c;
    repeat (4) @(posedge clk_sys);
    base = sum;
    hold <= 1'b1; // Active level kept after the edge
    pulse_go;
    repeat (2) @(posedge clk_sys); // Let the done of the last run fall first
    wait_done;
    check("locked", 32'(ref_locked), 32'h0);
    check("sum", sum - base, 32'hffffffec);
    check("acks", 32'(acks), 32'h2);
    repeat (40) @(posedge clk_sys);
    #1 check("bypass", 32'(filter_bypass), 32'h0);
    hold <= 1'b0;
    rd_chk("count", OFS_COUNT, 32'h0);
    $display("reverse run test done");
  endtask
  task stop_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset;
    t_locked;
    t_refuse;
    t_reverse;
    stop_test;
  end
endmodule
